// ==== uart_core.sv ====
// 16550-style serial port with queues, address match and modem lines
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "uart_core_params.svh"

module uart_core
  import uart_core_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // serial line
  input  wire logic       rxd,
  output logic            txd,
  output logic            txd_oe,
  // modem lines active low, output enables active high
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ri_n,
  input  wire logic       dcd_n,
  output logic            rts_n,
  output logic            rts_oe,
  output logic            dtr_n,
  output logic            dtr_oe
);

  // ==========================================================
  // state and helpers
  state_s q;
  state_s d;
  logic [3:0] cap;
  logic [3:0] lvl;
  logic [3:0] iir_code;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [7:0] err_v;
  logic       tout_hit;
  logic       line_irq;
  logic       am;
  logic [1:0] cl;
  logic [9:0] tlim;

  function automatic state_s rst_state();
    state_s s;
    s           = '0;
    s.adr       = `ADR_RESET;
    s.rts_allow = 1'b1;
    s.tx_line   = 1'b1;
    return s;
  endfunction : rst_state

  function automatic logic par_bit(input logic [7:0] v,
                                   input logic [1:0] len,
                                   input logic [1:0] kind);
    logic [7:0] m;
    m = v & (8'hFF >> (2'd3 - len));
    case (kind)
      `PAR_ODD:  par_bit = ~^m;
      `PAR_EVEN: par_bit = ^m;
      `PAR_MARK: par_bit = 1'b1;
      default:   par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // ==========================================================
  // derived status
  assign cl  = q.lcr[1:0];
  assign cap = q.qen ? `QUEUE_DEPTH : 4'h1;
  always_comb begin
    if (!q.qen) begin
      lvl = 4'h1;
    end else begin
      case (q.trig)
        2'b00:   lvl = 4'h1;
        2'b01:   lvl = 4'h2;
        2'b10:   lvl = 4'h4;
        default: lvl = 4'h7;
      endcase
    end
  end

  // per-entry error of bytes still held
  for (genvar i = 0; i < 8; i++) begin : g_err
    logic [2:0] rel;
    assign rel      = 3'(i) - q.rx_rp;
    assign err_v[i] = ({1'b0, rel} < q.rx_cnt) &&
                      (|q.rx_mem[i][10:8]);
  end

  // matching active only with parity and a real address
  assign am = q.lcr[`LCR_PAR_EN] && (q.adr != `ADR_RESET);

  // four character periods in 16x ticks
  assign tlim = 10'(4'd7 + {2'b0, cl} + {3'b0, q.lcr[`LCR_PAR_EN]} +
                {3'b0, q.lcr[`LCR_STOP]}) << `TOUT_SHIFT;
  assign tout_hit = q.tout >= tlim;
  assign line_irq = q.ier[`IER_LINE] && (q.brk | q.frm | q.perr | q.ovr);

  always_comb begin
    if (q.adr_if) begin
      iir_code = `IIR_ADDR;
    end else if (line_irq) begin
      iir_code = `IIR_LINE;
    end else if (q.ier[`IER_RXA] && q.rx_cnt >= lvl) begin
      iir_code = `IIR_RXA;
    end else if (q.ier[`IER_RXA] && tout_hit && q.rx_cnt != 4'h0) begin
      iir_code = `IIR_TOUT;
    end else if (q.ier[`IER_TXE] && q.thr_if) begin
      iir_code = `IIR_THR;
    end else if (q.ier[`IER_MODEM] && |q.msr_chg) begin
      iir_code = `IIR_MODEM;
    end else begin
      iir_code = `IIR_NONE;
    end
  end

  assign lsr_val = {|err_v,
                    q.tx_cnt == 4'h0 && q.tx_st == SER_IDLE,
                    q.tx_cnt == 4'h0,
                    q.brk, q.frm, q.perr, q.ovr,
                    q.rx_cnt != 4'h0};
  assign msr_val = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, q.msr_chg};

  // ==========================================================
  // next state
  always_comb begin
    logic [8:0]  psum;
    logic        s16;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic        fin;
    logic        perr_c;
    logic [7:0]  rdata;
    logic [10:0] rent;
    logic        sel;
    psum    = 9'({1'b0, q.pacc} + 9'd2);
    s16     = 1'b0;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_pop  = 1'b0;
    fin     = 1'b0;
    perr_c  = 1'b0;
    rdata   = 8'h00;
    rent    = 11'h000;
    sel     = 1'b0;
    d       = q;
    d.rd_q  = 8'h00;

    // reference clock 2*fsys/pre, then 16x divisor
    if (psum >= {2'b0, q.pre[6:0]}) begin
      d.pacc = (q.pre[6:0] < 7'h02) ? 8'h00 :
               8'(psum - {2'b0, q.pre[6:0]});
      if (q.dlcnt + 16'h0001 >= q.dl) begin
        d.dlcnt = 16'h0000;
        s16     = 1'b1;
      end else begin
        d.dlcnt = q.dlcnt + 16'h0001;
      end
    end else begin
      d.pacc = psum[7:0];
    end

    // transmitter
    case (q.tx_st)
      SER_IDLE: begin
        if (q.tx_cnt != 4'h0 && (!q.mcr[`MCR_AUTO] || !cts_n)) begin
          tx_pop   = 1'b1;
          d.tx_sh  = q.tx_mem[q.tx_rp];
          d.tx_par = par_bit(q.tx_mem[q.tx_rp], cl, q.lcr[5:4]);
          d.tx_st  = SER_START;
          d.tx_smp = 4'h0;
          d.listen = 1'b0;
        end
      end
      SER_START: begin
        if (s16) begin
          d.tx_smp = q.tx_smp + 4'h1;
          if (q.tx_smp == `SAMPLE_LAST) begin
            d.tx_st  = SER_DATA;
            d.tx_bit = 3'h0;
          end
        end
      end
      SER_DATA: begin
        if (s16) begin
          d.tx_smp = q.tx_smp + 4'h1;
          if (q.tx_smp == `SAMPLE_LAST) begin
            d.tx_sh  = q.tx_sh >> 1;
            d.tx_bit = q.tx_bit + 3'h1;
            if (q.tx_bit == {1'b1, cl}) begin
              d.tx_st  = q.lcr[`LCR_PAR_EN] ? SER_PAR : SER_STOP;
              d.tx_bit = 3'h0;
            end
          end
        end
      end
      SER_PAR: begin
        if (s16) begin
          d.tx_smp = q.tx_smp + 4'h1;
          if (q.tx_smp == `SAMPLE_LAST) begin
            d.tx_st = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (s16) begin
          d.tx_smp = q.tx_smp + 4'h1;
          if (q.tx_smp == `SAMPLE_LAST) begin
            if (q.lcr[`LCR_STOP] && q.tx_bit == 3'h0) begin
              d.tx_bit = 3'h1;
            end else begin
              d.tx_st = SER_IDLE;
            end
          end
        end
      end
      default: d.tx_st = SER_IDLE;
    endcase

    // receiver
    case (q.rx_st)
      SER_IDLE: begin
        if (!rxd) begin
          d.rx_st   = SER_START;
          d.rx_smp  = 4'h0;
          d.rx_zero = 1'b1;
        end
      end
      SER_START: begin
        if (s16) begin
          d.rx_smp = q.rx_smp + 4'h1;
          if (q.rx_smp == `SAMPLE_MID) begin
            d.rx_st  = rxd ? SER_IDLE : SER_DATA;
            d.rx_smp = 4'h0;
            d.rx_bit = 3'h0;
          end
        end
      end
      SER_DATA: begin
        if (s16) begin
          d.rx_smp = q.rx_smp + 4'h1;
          if (q.rx_smp == `SAMPLE_LAST) begin
            d.rx_sh   = {rxd, q.rx_sh[7:1]};
            d.rx_zero = q.rx_zero & ~rxd;
            d.rx_bit  = q.rx_bit + 3'h1;
            if (q.rx_bit == {1'b1, cl}) begin
              d.rx_st = q.lcr[`LCR_PAR_EN] ? SER_PAR : SER_STOP;
            end
          end
        end
      end
      SER_PAR: begin
        if (s16) begin
          d.rx_smp = q.rx_smp + 4'h1;
          if (q.rx_smp == `SAMPLE_LAST) begin
            d.rx_par = rxd;
            d.rx_st  = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (s16) begin
          d.rx_smp = q.rx_smp + 4'h1;
          if (q.rx_smp == `SAMPLE_LAST) begin
            fin     = 1'b1;
            d.rx_st = SER_IDLE;
          end
        end
      end
      default: d.rx_st = SER_IDLE;
    endcase

    // finished character: check, match address, queue
    if (fin) begin
      rdata  = q.rx_sh >> (2'd3 - cl);
      perr_c = q.lcr[`LCR_PAR_EN] &&
               (q.rx_par != par_bit(rdata, cl, q.lcr[5:4]));
      rent   = {q.rx_zero & ~rxd & ~(q.lcr[`LCR_PAR_EN] & q.rx_par),
                ~rxd, perr_c, rdata};
      if (am && perr_c) begin
        if (rdata == q.adr || rdata == `ADR_BCAST) begin
          d.listen = 1'b1;
          d.adr_if = 1'b1;
        end else begin
          d.listen = 1'b0;
        end
      end else if (!am || q.listen) begin
        if (q.rx_cnt < cap) begin
          rx_push = 1'b1;
        end else begin
          d.ovr = 1'b1;
        end
      end
    end

    // register reads
    if (rd_en) begin
      case (addr)
        `OFS_MODEM_CTRL: d.rd_q = {5'h00, q.mcr};
        `OFS_IER:        d.rd_q = {1'b0, q.ier};
        `OFS_FCR:        d.rd_q = {q.trig, 5'h00, q.qen};
        `OFS_LCR:        d.rd_q = q.lcr;
        `OFS_IIR: begin
          d.rd_q = {{2{q.qen}}, 2'b00, iir_code};
          d.adr_if = 1'b0;
          if (iir_code == `IIR_THR) begin
            d.thr_if = 1'b0;
          end
        end
        `OFS_LSR: begin
          d.rd_q = lsr_val;
          d.brk  = 1'b0;
          d.frm  = 1'b0;
          d.perr = 1'b0;
          d.ovr  = 1'b0;
        end
        `OFS_MSR: begin
          d.rd_q    = msr_val;
          d.msr_chg = 4'h0;
        end
        `OFS_DATA: begin
          d.rd_q = q.rx_mem[q.rx_rp][7:0];
          rx_pop = q.rx_cnt != 4'h0;
        end
        `OFS_RFC: d.rd_q = {4'h0, q.rx_cnt};
        `OFS_TFC: d.rd_q = {4'h0, q.tx_cnt};
        `OFS_DLL: d.rd_q = q.dl[7:0];
        `OFS_DLH: d.rd_q = q.dl[15:8];
        `OFS_PRE: d.rd_q = q.pre;
        `OFS_ADR: d.rd_q = q.adr;
        default:  d.rd_q = 8'h00;
      endcase
    end

    // register writes
    if (wr_en) begin
      case (addr)
        `OFS_MODEM_CTRL: d.mcr = wr_data[2:0];
        `OFS_IER: begin
          d.ier = wr_data[6:0];
          if (wr_data[`IER_TXE] && !q.ier[`IER_TXE] &&
              q.tx_cnt == 4'h0) begin
            sel = 1'b1;
          end
        end
        `OFS_FCR: begin
          d.trig = wr_data[7:6];
          d.qen  = wr_data[`FCR_QEN];
        end
        `OFS_LCR: d.lcr = wr_data;
        `OFS_DATA: begin
          d.thr_if = 1'b0;
          if (q.tx_cnt < cap) begin
            d.tx_mem[q.tx_wp] = wr_data;
            d.tx_wp = q.tx_wp + 3'h1;
          end
        end
        `OFS_DLL: d.dl[7:0]  = wr_data;
        `OFS_DLH: d.dl[15:8] = wr_data;
        `OFS_PRE: d.pre = wr_data;
        `OFS_ADR: begin
          d.adr    = wr_data;
          d.listen = 1'b0;
        end
        default: d.lcr = q.lcr;
      endcase
    end

    // queue pointers and counts
    if (rx_push) begin
      d.rx_mem[q.rx_wp] = rent;
      d.rx_wp = q.rx_wp + 3'h1;
    end
    if (rx_pop) begin
      d.rx_rp = q.rx_rp + 3'h1;
    end
    d.rx_cnt = q.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};
    if (tx_pop) begin
      d.tx_rp = q.tx_rp + 3'h1;
    end
    d.tx_cnt = q.tx_cnt +
               {3'h0, wr_en && addr == `OFS_DATA && q.tx_cnt < cap} -
               {3'h0, tx_pop};

    // error flags follow the byte coming to the head, except one pushed as the only held byte is read
    if (rx_pop && q.rx_cnt > 4'h1) begin
      rent = q.rx_mem[q.rx_rp + 3'h1];
    end
    if ((rx_pop && q.rx_cnt > 4'h1) ||
        (rx_push && q.rx_cnt == 4'h0)) begin
      d.brk  = d.brk | rent[10];
      d.frm  = d.frm | rent[9];
      d.perr = d.perr | rent[8];
    end

    // flushes leave the shifters alone
    if (wr_en && addr == `OFS_FCR && wr_data[`FCR_TX_FLUSH]) begin
      d.tx_wp  = 3'h0;
      d.tx_rp  = 3'h0;
      d.tx_cnt = 4'h0;
    end
    if (wr_en && addr == `OFS_FCR && wr_data[`FCR_RX_FLUSH]) begin
      d.rx_wp  = 3'h0;
      d.rx_rp  = 3'h0;
      d.rx_cnt = 4'h0;
    end

    // transmit empty event, set wins over clear
    if (sel || (tx_pop && d.tx_cnt == 4'h0)) begin
      d.thr_if = 1'b1;
    end
    if (!am) begin
      d.adr_if = 1'b0;
    end

    // receive idle timer
    if (q.rx_cnt == 4'h0 || rx_push || rx_pop || q.rx_st != SER_IDLE) begin
      d.tout = 10'h000;
    end else if (s16 && !tout_hit) begin
      d.tout = q.tout + 10'h001;
    end

    // auto request-to-send
    if (d.rx_cnt >= lvl) begin
      d.rts_allow = 1'b0;
    end else if (d.rx_cnt == 4'h0) begin
      d.rts_allow = 1'b1;
    end

    // modem change flags
    d.msr_prev = ~{dcd_n, ri_n, dsr_n, cts_n};
    d.msr_chg  = d.msr_chg | (d.msr_prev ^ q.msr_prev);

    // line level, break overrides
    case (d.tx_st)
      SER_START: d.tx_line = 1'b0;
      SER_DATA:  d.tx_line = d.tx_sh[0];
      SER_PAR:   d.tx_line = d.tx_par;
      default:   d.tx_line = 1'b1;
    endcase
    if (q.lcr[`LCR_BREAK]) begin
      d.tx_line = 1'b0;
    end

    if (wr_en && addr == `OFS_IER && wr_data[`IER_SOFT_RESET]) begin
      d = rst_state();
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= rst_state();
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data = q.rd_q;
  assign txd     = q.ier[`IER_TX_GATE] ? q.tx_line : 1'b1;
  assign txd_oe  = q.ier[`IER_TX_GATE];
  assign rts_n   = ~(q.mcr[`MCR_RTS] &
                     (~q.mcr[`MCR_AUTO] | q.rts_allow));
  assign rts_oe  = q.ier[`IER_RTS_GATE];
  assign dtr_n   = ~q.mcr[`MCR_DTR];
  assign dtr_oe  = q.ier[`IER_DTR_GATE];

  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  soft_reset_a: assert property (
    wr_en && addr == `OFS_IER && wr_data[`IER_SOFT_RESET]
    |=> q.ier == 7'h00 && q.tx_cnt == 4'h0 && q.rx_cnt == 4'h0)
    else $error("soft reset left state behind");
  rx_gate_a: assert property (
    !q.ier[`IER_RXA] |-> iir_code != `IIR_RXA && iir_code != `IIR_TOUT)
    else $error("receive interrupt while disabled");
  rx_trigger_a: assert property (
    q.ier[`IER_RXA] && !q.adr_if && !line_irq && q.rx_cnt >= lvl
    |-> iir_code == `IIR_RXA)
    else $error("receive trigger not reported");
  tx_flush_a: assert property (
    wr_en && addr == `OFS_FCR && wr_data[`FCR_TX_FLUSH]
    |=> q.tx_cnt == 4'h0)
    else $error("transmit queue not flushed");
  break_line_a: assert property (
    q.lcr[`LCR_BREAK] |=> !q.tx_line)
    else $error("break did not hold line low");
  iir_read_a: assert property (
    rd_en && addr == `OFS_IIR
    |=> rd_data[7:6] == {2{$past(q.qen)}}
        && rd_data[0] == ($past(iir_code) == `IIR_NONE))
    else $error("identification read wrong");
  tx_drain_a: assert property (
    q.tx_st != SER_IDLE |-> !lsr_val[6] ##1 (q.tx_st == SER_IDLE
    || !lsr_val[6]))
    else $error("drained flag while shifting");
  data_ready_a: assert property (
    rd_en && addr == `OFS_LSR
    |=> rd_data[0] == ($past(q.rx_cnt) != 4'h0))
    else $error("data ready disagrees with count");

endmodule : uart_core

// ==== uart_core_params.svh ====
// register offsets, field positions, reset values and codes of the uart core
`ifndef UART_CORE_PARAMS_SVH
`define UART_CORE_PARAMS_SVH
// ==========================================================
// register offsets
`define OFS_MODEM_CTRL 4'h0
`define OFS_IER        4'h1
`define OFS_FCR        4'h2
`define OFS_LCR        4'h3
`define OFS_IIR        4'h4
`define OFS_LSR        4'h5
`define OFS_MSR        4'h6
`define OFS_DATA       4'h8
`define OFS_RFC        4'hA
`define OFS_TFC        4'hB
`define OFS_DLL        4'hC
`define OFS_DLH        4'hD
`define OFS_PRE        4'hE
`define OFS_ADR        4'hF
// ==========================================================
// field positions
`define IER_SOFT_RESET 7
`define IER_TX_GATE    6
`define IER_RTS_GATE   5
`define IER_DTR_GATE   4
`define IER_MODEM      3
`define IER_LINE       2
`define IER_TXE        1
`define IER_RXA        0
`define FCR_TX_FLUSH   2
`define FCR_RX_FLUSH   1
`define FCR_QEN        0
`define LCR_BREAK      6
`define LCR_PAR_EN     3
`define LCR_STOP       2
`define MCR_AUTO       2
`define MCR_RTS        1
`define MCR_DTR        0
// ==========================================================
// reset values and codes
`define ADR_RESET      8'hFF
`define ADR_BCAST      8'hFF
`define QUEUE_DEPTH    4'h8
`define SAMPLE_MID     4'h7
`define SAMPLE_LAST    4'hF
`define TOUT_SHIFT     6
`define PAR_ODD        2'b00
`define PAR_EVEN       2'b01
`define PAR_MARK       2'b10
`define IIR_NONE       4'h1
`define IIR_ADDR       4'hE
`define IIR_LINE       4'h6
`define IIR_RXA        4'h4
`define IIR_TOUT       4'hC
`define IIR_THR        4'h2
`define IIR_MODEM      4'h0
`endif

// ==== uart_core_pkg.sv ====
// types of the uart core
package uart_core_pkg;
  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_START = 3'b001,
    SER_DATA  = 3'b010,
    SER_PAR   = 3'b011,
    SER_STOP  = 3'b100
  } ser_e;

  typedef struct packed {
    logic [2:0]        mcr;
    logic [6:0]        ier;
    logic [1:0]        trig;
    logic              qen;
    logic [7:0]        lcr;
    logic [15:0]       dl;
    logic [7:0]        pre;
    logic [7:0]        adr;
    logic [7:0]        pacc;
    logic [15:0]       dlcnt;
    logic [7:0][7:0]   tx_mem;
    logic [2:0]        tx_wp;
    logic [2:0]        tx_rp;
    logic [3:0]        tx_cnt;
    ser_e              tx_st;
    logic [7:0]        tx_sh;
    logic [3:0]        tx_smp;
    logic [2:0]        tx_bit;
    logic              tx_par;
    logic              tx_line;
    logic [7:0][10:0]  rx_mem;
    logic [2:0]        rx_wp;
    logic [2:0]        rx_rp;
    logic [3:0]        rx_cnt;
    ser_e              rx_st;
    logic [7:0]        rx_sh;
    logic [3:0]        rx_smp;
    logic [2:0]        rx_bit;
    logic              rx_par;
    logic              rx_zero;
    logic              brk;
    logic              frm;
    logic              perr;
    logic              ovr;
    logic              thr_if;
    logic              adr_if;
    logic              listen;
    logic              rts_allow;
    logic [9:0]        tout;
    logic [3:0]        msr_prev;
    logic [3:0]        msr_chg;
    logic [7:0]        rd_q;
  } state_s;
endpackage : uart_core_pkg

// ==== remote_link.sv ====
// remote serial transceiver facing the uart core, 8 data bits, parity bit only when sending with par_on
`timescale 1ns/10ps
// ==========================================================
// remote transceiver
module remote_link #(
  parameter int BIT = 16
) (
  // clock
  input  wire logic       clk_sys,
  // send request from the bench
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       par_on,
  input  wire logic       send_par,
  // serial lines
  output logic            rxd,
  input  wire logic       txd,
  // captured characters
  output logic      [7:0] got_byte,
  output int              got_n
);
  initial begin
    rxd      = 1'b1;
    got_byte = 8'h00;
    got_n    = 0;
  end

  // start low, lsb first, optional ninth bit, one high stop
  always @(posedge clk_sys) begin : tx_frame
    logic [10:0] f;
    int          n;
    f = par_on ? {1'b1, send_par, send_byte, 1'b0} :
                 {2'b11, send_byte, 1'b0};
    n = par_on ? 11 : 10;
    if (send) begin
      for (int i = 0; i < n; i++) begin
        rxd <= f[i];
        repeat (BIT) @(posedge clk_sys);
      end
    end
  end

  // sample mid bit, count only frames with a good stop
  always begin : rx_frame
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk_sys);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_sys);
        got_byte[i] = txd;
      end
      repeat (BIT) @(posedge clk_sys);
      if (txd === 1'b1) got_n = got_n + 1;
    end
  end
endmodule : remote_link

// ==== uart_core_bench.sv ====
// self-checking testbench of the uart core
`timescale 1ns/10ps
module uart_core_bench;
  // ==========================================================
  // signals
  logic       clk_sys   = 1'b0;
  logic       reset     = 1'b1;
  logic [3:0] addr      = 4'h0;
  logic [7:0] wr_data   = 8'h00;
  logic       wr_en     = 1'b0;
  logic       rd_en     = 1'b0;
  logic       cts_n     = 1'b1;
  logic       send      = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic       par_on    = 1'b0;
  logic       send_par  = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] got_byte;
  logic       rxd;
  logic       txd;
  logic       txd_oe;
  int         got_n;
  int         fail_count = 0;
  int         n_checks   = 0;
  logic [3:0] ra [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                          4'h6, 4'h7, 4'hA, 4'hB, 4'hF};
  logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h60,
                          8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

  always #20 clk_sys = ~clk_sys;

  // ==========================================================
  // instances
  uart_core uart_core_i (
    .clk_sys (clk_sys), .reset (reset), .addr (addr),
    .wr_data (wr_data), .wr_en (wr_en), .rd_en (rd_en),
    .rd_data (rd_data), .rxd (rxd), .txd (txd), .txd_oe (txd_oe),
    .cts_n (cts_n), .dsr_n (1'b1), .ri_n (1'b1), .dcd_n (1'b1),
    .rts_n (), .rts_oe (), .dtr_n (), .dtr_oe ()
  );

  remote_link #(.BIT(16)) remote_link_i (
    .clk_sys (clk_sys), .send (send), .send_byte (send_byte),
    .par_on (par_on), .send_par (send_par),
    .rxd (rxd), .txd (txd), .got_byte (got_byte), .got_n (got_n)
  );

  // ==========================================================
  // tasks
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, rd_data);
  endtask : rd

  task serial_in(input logic [7:0] b, input logic p);
    @(posedge clk_sys);
    send      <= 1'b1;
    send_byte <= b;
    send_par  <= p;
    @(posedge clk_sys);
    send      <= 1'b0;
    repeat (200) @(posedge clk_sys);
  endtask : serial_in

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    $display("test reset values done");
    wr(4'hC, 8'h01);
    wr(4'hE, 8'h01);
    wr(4'h3, 8'h03);
    wr(4'h1, 8'h40);
    chk("txd_oe", 8'h01, {7'h00, txd_oe});
    for (int k = 0; k < 4; k++) begin
      wr(4'h2, {k[1:0], 6'h01});
      rd(4'h2, {k[1:0], 6'h01});
    end
    $display("test trigger codes done");
    wr(4'h8, 8'hA5);
    for (int i = 0; i < 400 && got_n == 0; i++) @(posedge clk_sys);
    chk("remote byte", 8'hA5, got_byte);
    repeat (20) @(posedge clk_sys);
    rd(4'h5, 8'h60);
    rd(4'h4, 8'hC1);
    wr(4'h3, 8'h43);
    repeat (2) @(posedge clk_sys);
    chk("break line", 8'h00, {7'h00, txd});
    wr(4'h3, 8'h03);
    $display("test transmit done");
    wr(4'h2, 8'h41);
    wr(4'h1, 8'h41);
    serial_in(8'h3C, 1'b0);
    rd(4'h5, 8'h61);
    rd(4'h4, 8'hC1);
    serial_in(8'hC3, 1'b0);
    rd(4'h4, 8'hC4);
    rd(4'hA, 8'h02);
    rd(4'h8, 8'h3C);
    rd(4'h4, 8'hC1);
    rd(4'h8, 8'hC3);
    rd(4'h5, 8'h60);
    $display("test receive done");
    @(posedge clk_sys);
    cts_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(4'h6, 8'h11);
    rd(4'h6, 8'h10);
    $display("test modem status done");
    par_on <= 1'b1;
    wr(4'h3, 8'h2B);
    wr(4'hF, 8'h5A);
    serial_in(8'h11, 1'b1);
    rd(4'hA, 8'h00);
    serial_in(8'h5A, 1'b0);
    rd(4'h4, 8'hCE);
    rd(4'h4, 8'hC1);
    serial_in(8'h77, 1'b1);
    rd(4'hA, 8'h01);
    rd(4'h8, 8'h77);
    par_on <= 1'b0;
    $display("test address match done");
    wr(4'h1, 8'h80);
    rd(4'h3, 8'h00);
    rd(4'h1, 8'h00);
    chk("txd_oe", 8'h00, {7'h00, txd_oe});
    $display("test soft reset done");
    print_verdict;
  end

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    print_verdict;
  end
endmodule : uart_core_bench
